// ===== src/sacs_defines.svh
// Purpose: named constants of the serial converter sequencer
// Assumes: included by bare name from the link and sequencer files
// Notes: header holds definitions only
`ifndef SACS_DEFINES_SVH
`define SACS_DEFINES_SVH

// ==========================================================
// Command codes in the upper nibble of the input word
`define SACS_CMD_PWRDN 4'hE
`define SACS_CMD_CFG2 4'hF

// ==========================================================
// Data length codes and cycle lengths in falling edges
`define SACS_LEN_8 2'h1
`define SACS_LEN_16 2'h3
`define SACS_EDGES_8 5'h08
`define SACS_EDGES_12 5'h0C
`define SACS_EDGES_16 5'h10
`define SACS_ADDR_EDGE 5'h04
`define SACS_WORD_BITS 4'h8
`define SACS_WORD_TOP 4'h7
`define SACS_MSB_POS 4'hF

// ==========================================================
// Field positions of the configuration nibbles
`define SACS_CFG1_LEN_HI 3
`define SACS_CFG1_LEN_LO 2
`define SACS_CFG1_LSB 1
`define SACS_CFG1_BIP 0
`define SACS_CFG2_REF_HI 3
`define SACS_CFG2_REF_LO 2
`define SACS_CFG2_INT 1
`define SACS_CFG2_DEF 0

// ==========================================================
// Reset values and the bipolar sign mask
`define SACS_CFG1_RST 4'h0
`define SACS_CFG2_RST 4'hC
`define SACS_CHAN_RST 4'h0
`define SACS_SIGN_FLIP 12'h800

// ==========================================================
// Default cycle counts on the core clock
`define SACS_DEBOUNCE_CYCLES 4
`define SACS_CONV_CYCLES 14
`define SACS_SYNC_DEPTH 3

`endif

// ===== src/sacs_link.sv
// Purpose: I/O clock side of the sequencer: command capture,
//          edge counting, sample window and bit position
// Assumes: link_rst_i is a glitch-free flop from the core domain
// Notes: reset is asserted at any time and released only while
//        the I/O clock idles low
`timescale 1ns/1ns
`default_nettype none
`include "sacs_defines.svh"

module sacs_link
    import sacs_pkg::*;
(
    // Link clock and reset
    input wire logic io_clk_i,
    input wire logic link_rst_i,
    // Serial command and stored length
    input wire logic cmd_bit_i,
    input wire logic [1:0] cfg_len_i,
    // Status towards the core
    output logic [7:0] word_o,
    output logic held_o,
    output logic pd_cmd_o,
    output logic samp_o,
    output logic rise_seen_o,
    output logic [3:0] pos_o
);

    sacs_fall_t f_reg;
    sacs_fall_t f_next;
    sacs_rise_t r_reg;
    sacs_rise_t r_next;
    logic [1:0] len_code;
    logic [4:0] target;
    logic [4:0] edge_nr;

    // ======================================================
    // Rising edges: the host changes its bit on falling edges
    always_comb begin
        r_next = r_reg;
        r_next.seen = 1'b1;
        if (r_reg.cnt < `SACS_WORD_BITS) begin
            r_next.word[3'(`SACS_WORD_TOP - r_reg.cnt)] = cmd_bit_i;
            r_next.cnt = r_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge io_clk_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ======================================================
    // Falling edges
    always_comb begin
        f_next = f_reg;
        edge_nr = f_reg.edges + 5'h01;
        // SECONDARY_CONFIG_REGISTER access keeps the stored length
        if (r_reg.word[7:4] == `SACS_CMD_CFG2) begin
            len_code = cfg_len_i;
        end else begin
            len_code = r_reg.word[`SACS_CFG1_LEN_HI:`SACS_CFG1_LEN_LO];
        end
        unique case (len_code)
            `SACS_LEN_8: target = `SACS_EDGES_8;
            `SACS_LEN_16: target = `SACS_EDGES_16;
            default: target = `SACS_EDGES_12;
        endcase
        if (!f_reg.held) begin
            // count falling edges of the cycle
            f_next.edges = edge_nr;
            if (edge_nr == `SACS_ADDR_EDGE) begin
                // sampling opens after the fourth edge
                f_next.samp = 1'b1;
                // power-down code seen by edge four
                f_next.pd_cmd = (r_reg.word[7:4] == `SACS_CMD_PWRDN);
            end
            if (edge_nr == target) begin
                // hold on the final edge of the cycle
                f_next.held = 1'b1;
                f_next.samp = 1'b0;
            end else begin
                // each falling edge but the final one advances the output bit
                f_next.pos = edge_nr[3:0];
            end
        end
    end

    always_ff @(negedge io_clk_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    assign word_o = r_reg.word;
    assign held_o = f_reg.held;
    assign pd_cmd_o = f_reg.pd_cmd;
    assign samp_o = f_reg.samp;
    assign rise_seen_o = r_reg.seen;
    assign pos_o = f_reg.pos;

endmodule
`default_nettype wire

// ===== src/sacs_pkg.sv
// Purpose: types shared by the sequencer core and its link end
// Assumes: nothing
// Notes: counters are sized for parameters up to 255
package sacs_pkg;

    // ======================================================
    // Core states
    typedef enum logic [1:0] {
        sacs_idle,
        sacs_convert,
        sacs_flush
    } sacs_state_t;

    // ======================================================
    // Core domain state, bit [0] of each sync pair is stage one
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] held_sync;
        logic [1:0] pd_sync;
        logic [1:0] rise_sync;
        logic [1:0] samp_sync;
        logic held_seen;
        logic rise_seen;
        logic cs_prev;
        logic samp_prev;
        logic cs_db_low;
        logic [7:0] db_cnt;
        sacs_state_t state;
        logic [7:0] conv_cnt;
        logic [3:0] cfg1;
        logic [3:0] cfg2;
        logic [3:0] chan;
        logic [3:0] mux_sel;
        logic mux_en;
        logic sw_pd;
        logic auto_pd;
        logic int_pend;
        logic link_rst;
        logic status;
        logic [15:0] out_word;
    } sacs_core_t;

    // ======================================================
    // Link domain state on falling and rising I/O clock edges
    typedef struct packed {
        logic [4:0] edges;
        logic [3:0] pos;
        logic held;
        logic pd_cmd;
        logic samp;
    } sacs_fall_t;

    typedef struct packed {
        logic [7:0] word;
        logic [3:0] cnt;
        logic seen;
    } sacs_rise_t;

endpackage

// ===== src/sacs_sequencer.sv
// Purpose: control and sequencing of a serial SAR converter
// Assumes: clk_i is the internal conversion clock; the host
//          drives chip select, I/O clock and command bit
// Notes: the link end runs on the I/O clock, held in reset
//        while the core owns the cycle
`timescale 1ns/1ns
`default_nettype none
`include "sacs_defines.svh"

// Contract
// - EOC mode holds status high in reset
// - sampling after edge four, EOC high meanwhile
// - switch opens, EOC low at length edge
// - EOC rises after result latched, restarts cycle
// - CS low: first bit at EOC rise
// - CS toggled: first bit at CS fall
// - INT high until latched, low until cleared
// - CS low: first bit at INT fall
// - rising I/O clock clears pending interrupt
// - CS high: tristate now, clock ignored later
// - debounced CS fall resets the device
// - early abort keeps previous result
// - output forced low during conversion
// - code 1110b powers down at edge four
// - power-down: no conversion, reference off
// - start powered down until other code
// - auto power-down after conversion, reference on
// - sample from edge four, hold at last
// - mux breaks before make, tests alike
// - upper nibble is address, 1111b reaches SECONDARY_CONFIG_REGISTER
// - SECONDARY_CONFIG_REGISTER bit one selects EOC or INT
// - length codes give 8, 12, 16 edges
module sacs_sequencer
    import sacs_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = `SACS_DEBOUNCE_CYCLES,
    parameter int CONV_CYCLES = `SACS_CONV_CYCLES
) (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Host serial link
    input wire logic io_clk_i,
    input wire logic cs_n_i,
    input wire logic serial_command_input_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic status_o,
    // Analog side
    input wire logic [11:0] conv_result_i,
    output logic [3:0] mux_sel_o,
    output logic mux_en_o,
    output logic sample_o,
    output logic converting_o,
    // Power and reference
    output logic [1:0] ref_sel_o,
    output logic ref_pd_o,
    output logic sw_pd_o,
    output logic auto_pd_o,
    // Configuration view
    output logic [3:0] primary_config_register_o,
    output logic [3:0] secondary_config_register_o
);

    // ======================================================
    // Parameter checks
    generate
        if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 255) begin : g_db_chk
            $error("DEBOUNCE_CYCLES must lie in 1..255");
        end
        // The hold flag must drain through the sync before idle
        if (CONV_CYCLES < `SACS_SYNC_DEPTH || CONV_CYCLES > 255) begin : g_cv_chk
            $error("CONV_CYCLES must lie in 3..255");
        end
    endgenerate

    localparam logic [7:0] DB_LAST = 8'(DEBOUNCE_CYCLES - 1);
    localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

    // ======================================================
    // Signals
    sacs_core_t q;
    sacs_core_t n;
    logic [7:0] link_word;
    logic link_held;
    logic link_pd;
    logic link_samp;
    logic link_rise;
    logic [3:0] link_pos;
    logic [3:0] sdo_idx;
    logic held_rise;
    logic rise_evt;
    logic db_fall;
    logic cs_fall;
    logic samp_start;
    logic [3:0] cmd;
    logic [3:0] low_bits;

    // ======================================================
    // Link end on the I/O clock
    sacs_link u_link (
        .io_clk_i(io_clk_i),
        .link_rst_i(q.link_rst),
        .cmd_bit_i(serial_command_input_i),
        .cfg_len_i(q.cfg1[`SACS_CFG1_LEN_HI:`SACS_CFG1_LEN_LO]),
        .word_o(link_word),
        .held_o(link_held),
        .pd_cmd_o(link_pd),
        .samp_o(link_samp),
        .rise_seen_o(link_rise),
        .pos_o(link_pos)
    );

    // ======================================================
    // Result formatting into shift order, first bit at [15]
    function automatic logic [11:0] rev12(input logic [11:0] v);
        logic [11:0] r;
        r = '0;
        for (int i = 0; i < 12; i++) begin
            r[i] = v[11 - i];
        end
        return r;
    endfunction

    function automatic logic [15:0] fmt(
        input logic [11:0] res,
        input logic [3:0] cfg
    );
        logic [11:0] v;
        logic [11:0] r;
        logic [1:0] len;
        v = res;
        if (cfg[`SACS_CFG1_BIP]) begin
            v = res ^ `SACS_SIGN_FLIP;
        end
        r = rev12(v);
        len = cfg[`SACS_CFG1_LEN_HI:`SACS_CFG1_LEN_LO];
        if (len == `SACS_LEN_8) begin
            // Eight-bit mode drops the four low result bits, the four high ones when LSB first
            if (cfg[`SACS_CFG1_LSB]) begin
                return {r[11:4], 8'h00};
            end
            return {v[11:4], 8'h00};
        end
        // Twelve- and sixteen-bit modes pad four zeros after the result
        if (cfg[`SACS_CFG1_LSB]) begin
            return {r, 4'h0};
        end
        return {v, 4'h0};
    endfunction

    // ======================================================
    // Next state
    always_comb begin
        n = q;
        cmd = link_word[7:4];
        low_bits = link_word[3:0];
        // Stage one of each pair feeds stage two only
        n.cs_sync = {q.cs_sync[0], cs_n_i};
        n.held_sync = {q.held_sync[0], link_held};
        n.pd_sync = {q.pd_sync[0], link_pd};
        n.rise_sync = {q.rise_sync[0], link_rise};
        n.samp_sync = {q.samp_sync[0], link_samp};
        held_rise = q.held_sync[1] & ~q.held_seen;
        n.held_seen = q.held_sync[1];
        rise_evt = q.rise_sync[1] & ~q.rise_seen;
        n.rise_seen = q.rise_sync[1];
        cs_fall = q.cs_prev & ~q.cs_sync[1];
        n.cs_prev = q.cs_sync[1];
        samp_start = q.samp_sync[1] & ~q.samp_prev;
        n.samp_prev = q.samp_sync[1];
        db_fall = 1'b0;

        // debounce both edges of chip select
        if (q.cs_sync[1] == q.cs_db_low) begin
            if (q.db_cnt == DB_LAST) begin
                n.db_cnt = 8'h00;
                n.cs_db_low = ~q.cs_sync[1];
                db_fall = ~q.cs_sync[1];
            end else begin
                n.db_cnt = q.db_cnt + 8'h01;
            end
        end else begin
            n.db_cnt = 8'h00;
        end

        // resume shortly after chip select or sampling
        if (cs_fall || samp_start) begin
            n.auto_pd = 1'b0;
        end

        // host rising edge clears the interrupt
        if (rise_evt) begin
            n.int_pend = 1'b0;
        end

        // power-down takes hold at the fourth edge
        if (q.pd_sync[1] && q.state == sacs_idle && !q.link_rst) begin
            n.sw_pd = 1'b1;
        end

        unique case (q.state)
            sacs_idle: begin
                if (held_rise) begin
                    // upper nibble addresses, 1111b writes SECONDARY_CONFIG_REGISTER
                    if (cmd == `SACS_CMD_CFG2) begin
                        n.cfg2 = low_bits;
                    end else begin
                        n.cfg1 = low_bits;
                    end
                    if (cmd == `SACS_CMD_PWRDN) begin
                        n.state = sacs_flush;
                    end else if (cmd == `SACS_CMD_CFG2) begin
                        if (q.sw_pd) begin
                            n.state = sacs_flush;
                        end else begin
                            n.state = sacs_convert;
                        end
                    end else begin
                        // test voltages take the same path
                        n.chan = cmd;
                        n.sw_pd = 1'b0;
                        n.state = sacs_convert;
                    end
                    n.conv_cnt = 8'h00;
                    n.int_pend = 1'b0;
                    n.auto_pd = 1'b0;
                end
            end
            sacs_convert: begin
                if (q.conv_cnt == CONV_LAST) begin
                    // latch the result on the same clock edge that raises EOC or drops INT
                    n.out_word = fmt(conv_result_i, q.cfg1);
                    n.state = sacs_idle;
                    // interrupt pends once the result is latched
                    n.int_pend = 1'b1;
                    // idle converter drops into auto power-down
                    n.auto_pd = 1'b1;
                end else begin
                    n.conv_cnt = q.conv_cnt + 8'h01;
                end
            end
            sacs_flush: begin
                if (!q.held_sync[1]) begin
                    n.state = sacs_idle;
                end
            end
        endcase

        // a debounced low chip select resets the device
        if (db_fall) begin
            // aborted conversion leaves the old result
            n.state = sacs_idle;
            n.conv_cnt = 8'h00;
            n.int_pend = 1'b0;
        end

        // link frozen while chip select is high
        // link released again when the core returns to idle
        n.link_rst = ~n.cs_db_low | (n.state != sacs_idle);

        if (n.cfg2[`SACS_CFG2_INT]) begin
            // interrupt mode is low only while pending
            n.status = ~n.int_pend;
        end else begin
            // end-of-conversion high in reset and sampling
            // low from the hold edge until completion
            n.status = (n.state != sacs_convert);
        end

        // break the old channel before making the new one
        if (q.chan != q.mux_sel) begin
            if (q.mux_en) begin
                n.mux_en = 1'b0;
            end else begin
                n.mux_sel = q.chan;
            end
        end else begin
            n.mux_en = ~q.sw_pd;
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.cs_sync <= 2'h3;
            q.cs_prev <= 1'b1;
            q.cfg1 <= `SACS_CFG1_RST;
            q.cfg2 <= `SACS_CFG2_RST;
            q.chan <= `SACS_CHAN_RST;
            q.mux_sel <= `SACS_CHAN_RST;
            q.sw_pd <= 1'b1;
            q.link_rst <= 1'b1;
            q.status <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ======================================================
    // Serial output
    assign sdo_idx = `SACS_MSB_POS - link_pos;
    // with the link in reset the first bit is already shown
    // the same bit stands when the interrupt falls
    // forced low while a conversion runs
    assign sdo_o = (q.state == sacs_convert) ? 1'b0 : q.out_word[sdo_idx];
    // driven only while chip select is low
    // released straight from the pin, no debounce
    assign sdo_oe_o = ~cs_n_i;

    // ======================================================
    // Status, analog and power outputs
    assign status_o = q.status;
    assign mux_sel_o = q.mux_sel;
    assign mux_en_o = q.mux_en;
    // sample window straight from the link edges
    assign sample_o = link_samp;
    assign converting_o = (q.state == sacs_convert);
    assign ref_sel_o = q.cfg2[`SACS_CFG2_REF_HI:`SACS_CFG2_REF_LO];
    // reference off only in software power-down
    // auto power-down keeps the reference on
    assign ref_pd_o = q.sw_pd;
    assign sw_pd_o = q.sw_pd;
    assign auto_pd_o = q.auto_pd;
    assign primary_config_register_o = q.cfg1;
    assign secondary_config_register_o = q.cfg2;

endmodule
`default_nettype wire

// ===== tb/sacs_checker.sv
// Purpose: port checker of the conversion sequencer
// Assumes: every checked relation lives on the core clock
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module sacs_checker
    import sacs_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 4,
    parameter int CONV_CYCLES = 14
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link pins
    input wire logic cs_n_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic status_o,
    // Core outputs
    input wire logic [3:0] mux_sel_o,
    input wire logic mux_en_o,
    input wire logic sample_o,
    input wire logic converting_o,
    input wire logic ref_pd_o,
    input wire logic sw_pd_o,
    input wire logic auto_pd_o,
    input wire logic [3:0] secondary_config_register_o
);
    logic [7:0] conv_len_reg;
    logic int_mode;
    assign int_mode = secondary_config_register_o[1];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ====
    // Conversion length, so a stuck state shows up
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !converting_o) begin
            conv_len_reg <= 8'h00;
        end else begin
            conv_len_reg <= conv_len_reg + 8'h01;
        end
    end
    sequence s_conv_start;
        $rose(converting_o);
    endsequence
    sequence s_conv_end;
        $fell(converting_o);
    endsequence
    // ====
    // Assertions
    a_reset_status_high: assert property ($rose(rst_n_i) |-> status_o && sw_pd_o && !converting_o)
        else $error("status or power-down wrong after reset");
    a_oe_off_high: assert property (cs_n_i |-> !sdo_oe_o)
        else $error("output driven with chip select high");
    a_oe_on_low: assert property (!cs_n_i |-> sdo_oe_o)
        else $error("output released with chip select low");
    a_eoc_fall_conv: assert property (!int_mode ##0 s_conv_start |-> ##[0:1] !status_o)
        else $error("end-of-conversion did not fall");
    a_eoc_rise_done: assert property (!int_mode ##0 s_conv_end |-> ##[0:1] status_o)
        else $error("end-of-conversion did not rise");
    a_int_high_conv: assert property (int_mode && converting_o |-> status_o)
        else $error("interrupt low during conversion");
    a_hold_before_conv: assert property (converting_o |-> !sample_o)
        else $error("sampling switch closed while converting");
    a_sdo_low_conv: assert property (!int_mode && converting_o && !status_o && !cs_n_i |-> !sdo_o)
        else $error("serial output not forced low");
    a_pd_ref_off: assert property (sw_pd_o |-> ref_pd_o)
        else $error("reference powered in power-down");
    a_auto_ref_on: assert property (auto_pd_o && !sw_pd_o |-> !ref_pd_o)
        else $error("reference off in auto power-down");
    a_mux_break: assert property (!$stable(mux_sel_o) |-> !mux_en_o && !$past(mux_en_o))
        else $error("channel changed while switch enabled");
    a_conv_bounded: assert property (conv_len_reg <= CONV_CYCLES)
        else $error("conversion ran too long");
endmodule
bind sacs_sequencer sacs_checker #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .CONV_CYCLES(CONV_CYCLES)
) chk_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .status_o(status_o),
    .mux_sel_o(mux_sel_o),
    .mux_en_o(mux_en_o),
    .sample_o(sample_o),
    .converting_o(converting_o),
    .ref_pd_o(ref_pd_o),
    .sw_pd_o(sw_pd_o),
    .auto_pd_o(auto_pd_o),
    .secondary_config_register_o(secondary_config_register_o)
);
`default_nettype wire

// ===== tb/sacs_host.sv
// Purpose: host serial port facing the sequencer
// Assumes: the bench owns chip select and its debounce wait
// Notes: I/O clock runs only inside frames, 80 ns period
`timescale 1ns/1ns
`default_nettype none
module sacs_host (
    // Host serial lines
    output var logic io_clk_o,
    output var logic cmd_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    logic last_bit;
    initial begin
        io_clk_o = 1'b0;
        cmd_o = 1'b0;
        last_bit = 1'b0;
    end
    // whole frames of len clocks, only after a debounced fall
    task automatic frame(input logic [7:0] word, input int len, output logic [15:0] got);
        logic line;
        got = 16'h0000;
        #13;
        for (int k = 0; k < len; k++) begin
            // command byte leads, spare bits keep toggling
            cmd_o = (k < 8) ? word[3'(7 - k)] : ~cmd_o;
            // the first rise after the link is released also clears a pending interrupt
            #40 io_clk_o = 1'b1;
            // Released line shows the inverse, no pull on it
            line = sdo_oe_i ? sdo_i : ~last_bit;
            last_bit = line;
            got = {got[14:0], line};
            #40 io_clk_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of the sequencer
// Assumes: short debounce count, conversion count above the default
// Notes: chip select held low for the series, then toggled
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sacs_pkg::*;
    localparam int DB = 2;
    localparam int CV = 30;
    logic clk_i;
    logic rst_n_i;
    logic cs_n_i;
    logic io_clk;
    logic cmd;
    logic sdo_o;
    logic sdo_oe_o;
    logic status_o;
    logic converting_o;
    logic ref_pd_o;
    logic sw_pd_o;
    logic auto_pd_o;
    logic [11:0] conv_result_i;
    logic [3:0] cfg1;
    logic [3:0] cfg2;
    logic [1:0] ref_sel;
    logic [15:0] got;
    int n_mismatch;
    int checks;
    logic [7:0] words [9] = '{8'h30, 8'h2C, 8'h13, 8'h40, 8'h54, 8'hE0, 8'h60, 8'hFE, 8'h70};
    int lens [9] = '{12, 16, 12, 12, 8, 12, 12, 12, 12};
    logic [11:0] results [9] = '{12'hA5C, 12'h3C1, 12'h0F3, 12'hA61, 12'h5B2, 12'h000, 12'h1E4, 12'hAD7, 12'h2C8};
    logic [15:0] exps [9] = '{16'h0000, 16'hA5C0, 16'h03C1, 16'h0CF1, 16'h00A6, 16'h05B0, 16'h05B0, 16'h01E4,
        16'h0AD7};
    initial clk_i = 1'b0;
    always #50 clk_i = ~clk_i;
    sacs_sequencer #(.DEBOUNCE_CYCLES(DB), .CONV_CYCLES(CV)) dut_u (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .io_clk_i(io_clk),
        .cs_n_i(cs_n_i),
        .serial_command_input_i(cmd),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o),
        .status_o(status_o),
        .conv_result_i(conv_result_i),
        .mux_sel_o(),
        .mux_en_o(),
        .sample_o(),
        .converting_o(converting_o),
        .ref_sel_o(ref_sel),
        .ref_pd_o(ref_pd_o),
        .sw_pd_o(sw_pd_o),
        .auto_pd_o(auto_pd_o),
        .primary_config_register_o(cfg1),
        .secondary_config_register_o(cfg2)
    );
    sacs_host host_u (
        .io_clk_o(io_clk),
        .cmd_o(cmd),
        .sdo_i(sdo_o),
        .sdo_oe_i(sdo_oe_o)
    );
    // ====
    // Shared tasks
    task finish_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task check1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask
    task wait_conv(input logic v);
        for (int n = 0; n < 80; n++) begin
            if (converting_o === v) return;
            @(negedge clk_i);
        end
        n_mismatch++;
        finish_test();
    endtask
    task cs_low();
        @(posedge clk_i);
        cs_n_i <= 1'b0;
        // I/O clock stays low until the fall has debounced
        repeat (DB + 8) @(posedge clk_i);
    endtask
    // ====
    // Scenarios
    task run_series();
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_i);
            conv_result_i <= results[i];
            @(negedge clk_i);
            if (i > 0 && i != 6) check({15'h0000, sdo_o}, exps[i] >> (lens[i] - 1) & 16'h0001);
            host_u.frame(words[i], lens[i], got);
            if (i > 0) check(got, exps[i]);
            if (i == 8) check1(status_o, 1'b1);
            if (words[i][7:4] == 4'hE) begin
                repeat (8) @(negedge clk_i);
                check1(sw_pd_o, 1'b1);
                check1(ref_pd_o, 1'b1);
                check1(converting_o, 1'b0);
                check1(status_o, 1'b1);
            end else begin
                wait_conv(1'b1);
                @(negedge clk_i);
                check1(status_o, i >= 7);
                wait_conv(1'b0);
                repeat (4) @(negedge clk_i);
                check1(status_o, i < 7);
                check1(auto_pd_o, 1'b1);
            end
            if (words[i][7:4] != 4'hF) check({12'h000, cfg1}, {12'h000, words[i][3:0]});
            if (i == 0) check1(sw_pd_o, 1'b0);
            if (i == 7) check({12'h000, cfg2}, 16'h000E);
            if (i == 7) check({14'h0000, ref_sel}, 16'h0003);
            if (i == 6) repeat (10000) @(posedge clk_i);
        end
    endtask
    task abort_run();
        @(posedge clk_i);
        cs_n_i <= 1'b1;
        @(negedge clk_i);
        check1(sdo_oe_o, 1'b0);
        repeat (DB + 6) @(posedge clk_i);
        cs_low();
        conv_result_i <= 12'hFFF;
        @(negedge clk_i);
        check1(sdo_oe_o, 1'b1);
        check1(sdo_o, 1'b0);
        host_u.frame(8'h80, 12, got);
        check(got, 16'h02C8);
        wait_conv(1'b1);
        @(posedge clk_i);
        cs_n_i <= 1'b1;
        repeat (DB + 6) @(posedge clk_i);
        cs_low();
        @(negedge clk_i);
        check1(converting_o, 1'b0);
        host_u.frame(8'h90, 12, got);
        check(got, 16'h02C8);
    endtask
    initial begin
        rst_n_i = 1'b0;
        cs_n_i = 1'b1;
        conv_result_i = 12'h000;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        check1(status_o, 1'b1);
        check1(sw_pd_o, 1'b1);
        check({12'h000, cfg2}, 16'h000C);
        check1(sdo_oe_o, 1'b0);
        cs_low();
        run_series();
        abort_run();
        finish_test();
    end
endmodule
`default_nettype wire
